// >>> hw/rss_pkg.sv
// Constants and carrier types for the reset release and strap sampler.
// Assumes one 250 MHz reference clock that runs before reset release.
//
// What this block does
// - Reset rising edge starts self-configuration.
// - No output active while reset is low.
// - Test points tri-stated during reset.
// - Sample straps 1.5 us after release.
// - High strap selects test, low normal.
// - Test point 4 becomes output trigger one.
package rss_pkg;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_PS = 4000;
   localparam int STRAP_DELAY_NS = 1500;
   // Delay is approximate; round down, at least one cycle
   localparam int STRAP_DELAY_PS = STRAP_DELAY_NS * 1000;
   localparam int STRAP_DELAY_CYC_RAW = STRAP_DELAY_PS / CLK_PERIOD_PS;
   localparam int STRAP_DELAY_CYC =
      (STRAP_DELAY_CYC_RAW < 1) ? 1 : STRAP_DELAY_CYC_RAW;

   // ------------------------------------------------------------
   // Pins and reset values
   // ------------------------------------------------------------
   localparam int TEST_PINS = 8;
   localparam int TRIGGER_PIN = 4;
   localparam logic [7:0] STRAP_RESET = 8'h00;
   localparam logic [7:0] PIN_OE_N_RESET = 8'hff;

   typedef enum logic [1:0] {
      RSS_HOLD = 2'b00,
      RSS_WAIT = 2'b01,
      RSS_RUN = 2'b10
   } rss_state_e;

   typedef struct packed {
      logic [7:0] pinOut;
      logic [7:0] pinOutEn_n;
   } rss_pins_s;

endpackage

// >>> hw/rss_delay_counter.sv
// Down counter that times the strap-sampling delay.
// Assumes start is a one-cycle pulse in the reference clock domain.
`timescale 1ns/1ps
module rss_delay_counter
   import rss_pkg::*;
#(
   parameter int COUNT = STRAP_DELAY_CYC
)
(
   input wire logic clk,
   input wire logic reset,
   input wire logic clkEn,
   input wire logic start,
   output logic done
);
   localparam int CW = $clog2(COUNT + 1);
   logic [CW-1:0] count_r;
   logic busy_r;

   if (COUNT < 1)
   begin : g_bad_count
      $error("rss_delay_counter: COUNT must be at least one");
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         count_r <= '0;
         busy_r <= 1'b0;
         done <= 1'b0;
      end
      else if (clkEn)
      begin
         done <= 1'b0;
         if (start)
         begin
            count_r <= CW'(COUNT - 1);
            busy_r <= 1'b1;
         end
         else if (busy_r)
         begin
            if (count_r == '0)
            begin
               busy_r <= 1'b0;
               done <= 1'b1;
            end
            else
               count_r <= count_r - 1'b1;
         end
      end
   end
endmodule // rss_delay_counter

// >>> hw/reset_strap_sampler.sv
// Reset release and test-point strap sampling of a display controller.
// Assumes power_on_reset_n is asynchronous to clk and clk runs stably.
`timescale 1ns/1ps
module reset_strap_sampler
   import rss_pkg::*;
#(
   parameter int DELAY_CYC = STRAP_DELAY_CYC
)
(
   input wire logic clk,
   input wire logic reset,
   input wire logic clkEn,
   input wire logic power_on_reset_n,
   input wire logic [TEST_PINS-1:0] testPointIn,
   input wire logic output_trigger_one,
   input wire logic [TEST_PINS-1:0] testOutData,
   input wire logic scan_port_reset_n,
   output rss_pins_s testPoints,
   output logic [TEST_PINS-1:0] strapMode,
   output logic testModeActive,
   output logic configStart,
   output logic running
);

   if (DELAY_CYC < 1)
   begin : g_bad_delay
      $error("reset_strap_sampler: DELAY_CYC must be positive");
   end

   // ------------------------------------------------------------
   // Reset release synchroniser
   // ------------------------------------------------------------
   // Pin is asynchronous; first stage feeds only the second
   // Flops reset to the pin's idle high level, so a block reset with the
   // pin already high gives no false rise; a sequence needs a real low
   logic porMeta_r;
   logic porSync_r;
   logic porPrev_r;
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         porMeta_r <= 1'b1;
         porSync_r <= 1'b1;
         porPrev_r <= 1'b1;
      end
      else if (clkEn)
      begin
         porMeta_r <= power_on_reset_n;
         porSync_r <= porMeta_r;
         porPrev_r <= porSync_r;
      end
   end

   logic porRise;
   assign porRise = porSync_r && !porPrev_r;

   // ------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------
   rss_state_e state_r;
   logic delayDone;

   rss_delay_counter #(
      .COUNT(DELAY_CYC)
   ) u_delay (
      .clk(clk),
      .reset(reset),
      .clkEn(clkEn),
      .start(porRise),
      .done(delayDone)
   );

   always_ff @(posedge clk)
   begin
      if (reset)
         state_r <= RSS_HOLD;
      else if (clkEn)
      begin
         // Reset low at any time drops back to idle outputs
         if (!porSync_r)
            state_r <= RSS_HOLD;
         else
         begin
            unique case (state_r)
               RSS_HOLD:
                  if (porRise)
                     state_r <= RSS_WAIT;
               RSS_WAIT:
                  if (delayDone)
                     state_r <= RSS_RUN;
               RSS_RUN:
                  state_r <= RSS_RUN;
               default:
                  state_r <= RSS_HOLD;
            endcase
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (reset)
         configStart <= 1'b0;
      else if (clkEn)
         configStart <= porRise && state_r == RSS_HOLD;
   end

   // ------------------------------------------------------------
   // Strap capture
   // ------------------------------------------------------------
   // Pins are already held stable by straps; no extra synchroniser
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         strapMode <= STRAP_RESET;
         testModeActive <= 1'b0;
      end
      else if (clkEn)
      begin
         if (!porSync_r)
         begin
            strapMode <= STRAP_RESET;
            testModeActive <= 1'b0;
         end
         else if (state_r == RSS_WAIT && delayDone)
         begin
            strapMode <= testPointIn;
            testModeActive <= |testPointIn;
         end
      end
   end

   // ------------------------------------------------------------
   // Pin drive
   // ------------------------------------------------------------
   logic drive;
   assign drive = state_r == RSS_RUN && porSync_r;

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         testPoints.pinOut <= '0;
         testPoints.pinOutEn_n <= PIN_OE_N_RESET;
         running <= 1'b0;
      end
      else if (clkEn)
      begin
         running <= drive;
         if (!drive)
         begin
            // Floating: the board pull, high or low, sets the pad level
            testPoints.pinOut <= '0;
            testPoints.pinOutEn_n <= PIN_OE_N_RESET;
         end
         else
         begin
            testPoints.pinOutEn_n <= '0;
            for (int i = 0; i < TEST_PINS; i++)
               testPoints.pinOut[i] <= (i == TRIGGER_PIN) ?
                  output_trigger_one : testOutData[i];
         end
      end
   end

   // ------------------------------------------------------------
   // Wait length monitor
   // ------------------------------------------------------------
   // Counts enabled cycles spent waiting; read only by the check below
   localparam int WCW = $clog2(DELAY_CYC + 2);
   logic [WCW-1:0] waitCycles_r;
   always_ff @(posedge clk)
   begin
      if (reset)
         waitCycles_r <= '0;
      else if (clkEn)
      begin
         if (state_r == RSS_WAIT)
            waitCycles_r <= waitCycles_r + 1'b1;
         else
            waitCycles_r <= '0;
      end
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   a_pins_tristate:
   assert property (@(posedge clk) disable iff (reset)
      clkEn && !porSync_r |=> testPoints.pinOutEn_n == PIN_OE_N_RESET)
   else $error("test points driven during reset");

   a_no_active_out:
   assert property (@(posedge clk) disable iff (reset)
      clkEn && !porSync_r |=> !running && !testModeActive)
   else $error("outputs active during reset");

   a_start_pulse:
   assert property (@(posedge clk) disable iff (reset)
      clkEn && porRise && state_r == RSS_HOLD |=> configStart)
   else $error("configuration start missing");

   a_strap_taken:
   assert property (@(posedge clk) disable iff (reset)
      clkEn && state_r == RSS_WAIT && delayDone && porSync_r
      |=> strapMode == $past(testPointIn))
   else $error("straps not captured");

   a_test_select:
   assert property (@(posedge clk) disable iff (reset)
      running |-> testModeActive == (strapMode != '0))
   else $error("test mode does not follow straps");

   a_trigger_drive:
   assert property (@(posedge clk) disable iff (reset)
      clkEn && drive |=> !testPoints.pinOutEn_n[TRIGGER_PIN]
      && testPoints.pinOut[TRIGGER_PIN] == $past(output_trigger_one))
   else $error("trigger pin not driven");

   a_sync_path:
   assert property (@(posedge clk) disable iff (reset)
      clkEn ##1 clkEn |-> porSync_r == $past(porMeta_r))
   else $error("reset synchroniser broken");

   a_wait_length:
   assert property (@(posedge clk) disable iff (reset)
      state_r == RSS_WAIT ##1 state_r == RSS_RUN
      |-> waitCycles_r == WCW'(DELAY_CYC + 1))
   else $error("strap sampling delay has wrong length");

endmodule // reset_strap_sampler

// >>> tb/rss_power_model.sv
// Power-management part and board straps facing the sampler.
// Assumes tasks are called just after a rising clock edge.
`timescale 1ns/1ps
module rss_power_model
   import rss_pkg::*;
(
   input wire logic clk,
   input wire logic [7:0] pullUps,
   input rss_pins_s pins,
   output logic porN,
   output logic scanRstN,
   output logic [7:0] padLevel
);
   // Released pads fall to the pull level; nothing else drives them
   always_comb
   begin
      for (int i = 0; i < 8; i++)
         padLevel[i] = pins.pinOutEn_n[i] ? pullUps[i] : pins.pinOut[i];
   end

   initial
   begin
      porN = 1'b0;
      scanRstN = 1'b0;
   end

   task automatic hold_por();
      porN = 1'b0;
   endtask

   // Settle time stands in for supplies and clocks becoming stable
   task automatic release_por(input int settle);
      repeat (settle) @(posedge clk);
      #1 porN = 1'b1;
   endtask
endmodule // rss_power_model

// >>> tb/reset_strap_sampler_bench.sv
// Self-checking bench for the reset release and strap sampler.
// Assumes the power model drives reset pin and pads.
`timescale 1ns/1ps
module reset_strap_sampler_bench
   import rss_pkg::*;
;
   localparam int D = 4;
   logic clk, reset, clkEn, trig, porN, scanRstN, tma, cfgStart, running;
   logic [7:0] pullUps, outData, pad, strapMode, expPins;
   logic [7:0] expQ[$];
   rss_pins_s pins;
   int bad_count = 0;
   int tests_run = 0;
   int n;

   rss_power_model u_rss_power_model (.clk(clk), .pullUps(pullUps),
      .pins(pins), .porN(porN), .scanRstN(scanRstN), .padLevel(pad));

   reset_strap_sampler #(.DELAY_CYC(D)) u_reset_strap_sampler (.clk(clk),
      .reset(reset), .clkEn(clkEn), .power_on_reset_n(porN),
      .testPointIn(pad), .output_trigger_one(trig), .testOutData(outData),
      .scan_port_reset_n(scanRstN), .testPoints(pins),
      .strapMode(strapMode), .testModeActive(tma),
      .configStart(cfgStart), .running(running));

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic complete_run();
      $display("Counts: %0d compares, %0d mismatches", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic step();
      @(posedge clk);
      #1;
   endtask

   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   task automatic check_idle();
      check(pins.pinOutEn_n, 8'hff);
      check(pins.pinOut, 8'h00);
      check({5'h00, tma, cfgStart, running}, 8'h00);
      check(strapMode, 8'h00);
   endtask

   // Bounded wait for the start pulse; a timeout ends the run
   task automatic wait_start();
      n = 0;
      while (cfgStart !== 1'b1 && n < 20)
      begin
         step();
         n++;
      end
      check(8'(n < 20), 8'h01);
      if (n == 20)
         complete_run();
   endtask

   task automatic wait_run(input int expSteps);
      n = 0;
      while (running !== 1'b1 && n < 50)
      begin
         step();
         n++;
      end
      check(8'(n), 8'(expSteps));
      if (n == 50)
         complete_run();
   endtask

   task automatic check_driven();
      expPins = expQ.pop_front();
      check(strapMode, expPins);
      check(8'(tma), 8'(|expPins));
      check(pins.pinOutEn_n, 8'h00);
      check(pins.pinOut, (outData & 8'hef) | {3'b000, trig, 4'h0});
      trig = ~trig;
      step();
      check(8'(pins.pinOut[TRIGGER_PIN]), 8'(trig));
   endtask

   // One power-on cycle; a freeze stretches the wait by its own length
   task automatic power_cycle(input int freeze);
      expQ.push_back(pullUps);
      u_rss_power_model.hold_por();
      repeat (4) step();
      check_idle();
      u_rss_power_model.release_por(3);
      wait_start();
      if (freeze > 0)
      begin
         clkEn = 1'b0;
         repeat (freeze) step();
         check(8'(cfgStart), 8'h01);
         clkEn = 1'b1;
      end
      step();
      check(8'(cfgStart), 8'h00);
      wait_run(D + 1);
      check_driven();
   endtask

   initial
   begin
      reset = 1'b1;
      clkEn = 1'b1;
      trig = 1'b0;
      pullUps = 8'h00;
      outData = 8'h00;
      void'($urandom(32'hbffb));
      repeat (3) @(posedge clk);
      #1 reset = 1'b0;
      for (int k = 0; k < 4; k++)
      begin
         // First pass keeps all straps low, i.e. normal operation
         pullUps = (k == 0) ? 8'h00 : 8'($urandom);
         outData = 8'($urandom);
         trig = k[0];
         power_cycle((k == 3) ? 1 + int'($urandom % 4) : 0);
         $display("Test %0d done, straps %h", k, strapMode);
      end
      // Block reset while running, pin high: idle, and no false start
      reset = 1'b1;
      step();
      check_idle();
      reset = 1'b0;
      repeat (D + 8) step();
      check_idle();
      pullUps = 8'($urandom);
      power_cycle(0);
      $display("Test 4 done, straps %h", strapMode);
      // Pin falling during the wait abandons the sequence
      u_rss_power_model.hold_por();
      repeat (4) step();
      u_rss_power_model.release_por(3);
      wait_start();
      u_rss_power_model.hold_por();
      repeat (D + 4) step();
      check_idle();
      $display("Test 5 done, sequence cut");
      complete_run();
   end
endmodule // reset_strap_sampler_bench
